// ==== include/msg_params.svh ====
// Constants for the fast bus message handler: register offsets, field
// positions, reset values and timing counts. Included by the package; the design uses its macros without including it.
`ifndef MSG_PARAMS_SVH
`define MSG_PARAMS_SVH
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_ISTAT 8'h08
`define OFS_IMASK 8'h0c
`define OFS_SRE 8'h10
`define CTRL_MEP 0
`define MEP_RESET 1'h1
`define EV_TERM 0
`define EV_QDONE 1
`define EV_ERR 2
`define EV_CLEAR 3
`define EV_TRIG 4
`define EV_N 5
`define STB_MAV 4
`define STB_RQS 6
`define LF_BYTE 8'h0a
`define CLK_PERIOD_NS 10
`define BLINK_HALF_MS 250
`endif

// ==== include/msg_pkg.sv ====
// Types shared by the fast bus message handler and its surroundings.
// Assumes msg_params.svh is on the include path.
`include "msg_params.svh"
package msg_pkg;
	typedef struct packed {
		logic dcl;
		logic sdc;
		logic ifc;
		logic get;
		logic llo;
		logic gtl;
	} bus_evt_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} fmt_byte_s;
	typedef enum logic [1:0] {
		OUT_IDLE = 2'b00,
		OUT_FMT = 2'b01,
		OUT_SEND = 2'b10
	} out_state_e;
endpackage

// ==== testbench/gpib_ctl_model.sv ====
// Bus controller model: offers listener bytes and reads reply bytes.
// Assumes the handler's listener and talker ports on the same clock.
`timescale 1ns/100ps
`default_nettype none
module gpib_ctl_model (
	input wire logic mclk, // Clock.
	input wire logic rx_ready, // Hold-off from the device.
	input wire logic tx_valid, // Reply byte offered.
	input wire logic [7:0] tx_byte, // Reply byte.
	input wire logic tx_eoi, // EOI with reply byte.
	output logic rx_valid, // Byte offered.
	output logic [7:0] rx_byte, // Byte.
	output logic rx_eoi, // EOI with byte.
	output logic talk_addr, // Addressed to talk.
	output logic tx_req, // Data wanted.
	output logic tx_take // Byte taken.
);
	initial begin
		{rx_valid, rx_byte, rx_eoi, talk_addr, tx_req, tx_take} = '0;
	end
	// Released data shows its inverse, so a late sample of a stale byte cannot pass.
	task automatic send(input logic [7:0] b, input logic e);
		int n;
		n = 0;
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_byte <= b;
		rx_eoi <= e;
		do begin
			@(posedge mclk);
			n++;
		end while (rx_ready !== 1'b1 && n < 200);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
		rx_eoi <= ~e;
	endtask
	task automatic rd_byte(output logic [7:0] b, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		talk_addr <= 1'b1;
		tx_req <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (tx_valid !== 1'b1 && n < 200);
		b = tx_byte;
		e = tx_eoi;
		tx_take <= 1'b1;
		@(posedge mclk);
		tx_take <= 1'b0;
		tx_req <= 1'b0;
	endtask
	task automatic talk(input logic on);
		@(posedge mclk);
		talk_addr <= on;
		tx_req <= on;
	endtask
endmodule
`default_nettype wire

// ==== testbench/test_fast_bus_message_handler.sv ====
// Self-checking bench for the fast bus message handler.
// Assumes msg_pkg is compiled first; the bench plays parser and formatter.
`timescale 1ns/100ps
`default_nettype none
module test_fast_bus_message_handler;
	import msg_pkg::*;
	logic mclk = 1'b0;
	logic led_q = 1'b0;
	logic rst, reg_wr, reg_rd, ren, local_key, nv_mode, irq, rx_valid, rx_eoi, rx_ready;
	logic cmd_valid, cmd_eol, dev_clear, talk_addr, tx_req, tx_take, tx_valid, tx_eoi, e;
	logic fmt_start, fmt_implied, fmt_ready, srq, trig, mep_on, nv_save, remote_led, lockout;
	logic [7:0] reg_addr, rx_byte, cmd_byte, tx_byte, stb, b;
	logic [31:0] reg_wdata, reg_rdata;
	logic [3:0] par;
	bus_evt_s bus_evt;
	fmt_byte_s fmt_in;
	int failures, n_compared, n_eol, n_start, n_impl, n_clr, n_trig, n_save, n_blink, fmt_n;
	always #5 mclk = ~mclk;
	fast_bus_message_handler #(.BLINK_CYC(4)) DUT (
		.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.rx_valid, .rx_byte, .rx_eoi, .rx_ready, .cmd_valid, .cmd_byte, .cmd_eol,
		.query_seen(par[3]), .query_done(par[2]), .exec_done(par[1]), .exec_error(par[0]),
		.dev_clear, .bus_evt, .ren, .local_key, .talk_addr, .tx_req, .tx_take, .tx_valid,
		.tx_byte, .tx_eoi, .fmt_start, .fmt_implied, .fmt_ready, .fmt_in, .stb, .srq, .trig,
		.mep_on, .nv_mode, .nv_save, .remote_led, .lockout
	);
	gpib_ctl_model u (
		.mclk, .rx_ready, .tx_valid, .tx_byte, .tx_eoi, .rx_valid, .rx_byte, .rx_eoi,
		.talk_addr, .tx_req, .tx_take
	);
	// Pulses are sampled before the edge updates, so each is counted once.
	always @(posedge mclk) begin
		if (cmd_eol === 1'b1) n_eol++;
		if (fmt_start === 1'b1) n_start++;
		if (fmt_start === 1'b1 && fmt_implied === 1'b1) n_impl++;
		if (dev_clear === 1'b1) n_clr++;
		if (trig === 1'b1) n_trig++;
		if (nv_save === 1'b1) n_save++;
		if (remote_led !== led_q) n_blink++;
		led_q <= remote_led;
	end
	// Formatter stand-in: one byte per request, counting down to the last.
	always @(posedge mclk) begin
		if (fmt_in.valid && fmt_ready) fmt_n <= fmt_n - 1;
		fmt_in.valid <= fmt_ready && !fmt_in.valid && fmt_n != 0;
		fmt_in.data <= 8'h30 + 8'(fmt_n);
		fmt_in.last <= fmt_n == 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, x);
	endtask
	task automatic pls(input logic [3:0] p, input bus_evt_s v);
		@(posedge mclk);
		par <= p;
		bus_evt <= v;
		@(posedge mclk);
		par <= 4'h0;
		bus_evt <= '0;
		#1;
	endtask
	task automatic key();
		local_key <= 1'b1;
		wt(6);
		local_key <= 1'b0;
		wt(4);
	endtask
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#50000;
		failures++;
		close_out();
	end
	initial begin
		{rst, reg_wr, reg_rd, ren, local_key, nv_mode} = 6'b100000;
		{reg_addr, reg_wdata, par, bus_evt, fmt_in} = '0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		ren <= 1'b1;
		wt(3);
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h0);
		rdc(8'h14, 32'h0);
		wr(8'h10, 32'h1);
		u.send(8'h41, 1'b0);
		u.send(8'h0a, 1'b0);
		wt(2);
		chk(rx_ready, 1);
		chk(n_eol, 0);
		u.send(8'h0a, 1'b1);
		wt(1);
		chk(rx_ready, 0);
		chk(n_eol, 1);
		wt(3);
		chk(rx_ready, 0);
		pls(4'b0010, '0);
		chk(rx_ready, 1);
		u.send(8'h41, 1'b0);
		u.send(8'h0a, 1'b1);
		pls(4'b0001, '0);
		chk(rx_ready, 1);
		fmt_n = 1;
		u.rd_byte(b, e);
		chk({e, b}, 9'h131);
		chk(n_impl, 1);
		u.talk(1'b0);
		u.send(8'h3f, 1'b0);
		pls(4'b1000, '0);
		u.send(8'h0a, 1'b1);
		pls(4'b0100, '0);
		wt(2);
		chk(stb[4], 1);
		chk(srq, 1);
		chk(n_start, 1);
		pls(4'b0010, '0);
		fmt_n = 2;
		u.rd_byte(b, e);
		chk({e, b}, 9'h032);
		u.talk(1'b0);
		wt(3);
		u.rd_byte(b, e);
		chk({e, b}, 9'h131);
		wt(2);
		chk(stb[4], 0);
		chk(n_start, 2);
		chk(n_impl, 1);
		u.talk(1'b0);
		u.send(8'h3f, 1'b0);
		pls(4'b1000, '0);
		u.send(8'h0a, 1'b1);
		pls(4'b0110, '0);
		wt(2);
		chk(stb[4], 1);
		pls(4'b0000, 6'b100000);
		wt(2);
		chk(stb, 8'h00);
		chk(n_clr, 1);
		fmt_n = 1;
		u.rd_byte(b, e);
		chk(n_impl, 2);
		u.talk(1'b0);
		u.send(8'h41, 1'b0);
		u.talk(1'b1);
		wt(3);
		chk(rx_ready, 0);
		chk(n_start, 3);
		u.talk(1'b0);
		pls(4'b0000, 6'b001000);
		wt(1);
		chk(rx_ready, 1);
		chk(n_clr, 2);
		pls(4'b0000, 6'b000100);
		wt(1);
		chk(n_trig, 1);
		pls(4'b0000, 6'b000010);
		key();
		rdc(8'h04, 32'hc0);
		chk(n_blink > 1, 1);
		pls(4'b0000, 6'b000001);
		key();
		rdc(8'h04, 32'h0);
		wr(8'h00, 32'h1);
		wt(2);
		chk(mep_on, 1);
		chk(n_save, 1);
		rdc(8'h00, 32'h1);
		pls(4'b0000, 6'b000010);
		chk(lockout, 1);
		@(posedge mclk);
		ren <= 1'b0;
		wt(2);
		rdc(8'h04, 32'h1);
		ren <= 1'b1;
		u.send(8'h41, 1'b0);
		u.send(8'h0a, 1'b1);
		wt(1);
		chk(rx_ready, 1);
		pls(4'b0010, '0);
		rdc(8'h08, 32'h1f);
		chk(irq, 0);
		wr(8'h0c, 32'h4);
		wt(2);
		chk(irq, 1);
		wr(8'h08, 32'h1f);
		wt(2);
		chk(irq, 0);
		rdc(8'h08, 32'h0);
		@(posedge mclk);
		rst <= 1'b1;
		nv_mode <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		wt(2);
		chk(mep_on, 1);
		chk(n_save, 1);
		chk(irq, 0);
		rdc(8'h00, 32'h1);
		close_out();
	end
endmodule
`default_nettype wire

// ==== verilog/fast_bus_message_handler.sv ====
// Fast bus message handler: in fast mode holds off the listener at each line end and runs
// trigger-on-talk; paces reply bytes and keeps the remote and lockout state.
// Assumes a bus core on mclk that decodes bus commands and handshakes, and a
// parser and reply formatter on mclk; only the local key is asynchronous.
`timescale 1ns/100ps
`default_nettype none
module fast_bus_message_handler #(
	parameter int BLINK_CYC = (`BLINK_HALF_MS * 1000000) / `CLK_PERIOD_NS
) (
	input wire logic mclk, // System clock.
	input wire logic rst, // Synchronous reset.
	input wire logic [7:0] reg_addr, // Register address.
	input wire logic [31:0] reg_wdata, // Register write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [31:0] reg_rdata, // Read data, cycle after strobe.
	output logic irq, // Level interrupt.
	input wire logic rx_valid, // Listener byte offered.
	input wire logic [7:0] rx_byte, // Listener byte.
	input wire logic rx_eoi, // EOI with the byte.
	output logic rx_ready, // Low holds off the handshake.
	output logic cmd_valid, // Byte to parser.
	output logic [7:0] cmd_byte, // Parser byte.
	output logic cmd_eol, // Byte ended the line.
	input wire logic query_seen, // Parser found a query.
	input wire logic query_done, // Query processing finished.
	input wire logic exec_done, // All commands of line done.
	input wire logic exec_error, // Parser or command error.
	output logic dev_clear, // Clear pulse to parser.
	input wire msg_pkg::bus_evt_s bus_evt, // Decoded bus commands.
	input wire logic ren, // Remote enable level.
	input wire logic local_key, // Front panel key, async.
	input wire logic talk_addr, // Addressed to talk.
	input wire logic tx_req, // Controller wants a byte.
	input wire logic tx_take, // Controller took the byte.
	output logic tx_valid, // Reply byte presented.
	output logic [7:0] tx_byte, // Reply byte.
	output logic tx_eoi, // EOI with reply byte.
	output logic fmt_start, // Start reply formatting.
	output logic fmt_implied, // Implied read request.
	output logic fmt_ready, // Ready for next reply byte.
	input wire msg_pkg::fmt_byte_s fmt_in, // Formatter byte.
	output logic [7:0] stb, // Serial poll status byte.
	output logic srq, // Service request.
	output logic trig, // Trigger pulse.
	output logic mep_on, // Full protocol selected.
	input wire logic nv_mode, // Stored mode at power-up.
	output logic nv_save, // Store mode pulse.
	output logic remote_led, // Blinking remote indicator.
	output logic lockout // Local lockout active.
);
	import msg_pkg::*;

	if (BLINK_CYC < 2) begin : g_chk
		$error("BLINK_CYC must be at least 2");
	end

	logic mode_q, mode_d, loaded_q;
	logic hold_q, hold_d, stuck_q, stuck_d, open_q, open_d;
	logic pend_q, pend_d, mav_q, mav_d;
	logic [31:0] rdata_q, rdata_d;
	logic [`EV_N-1:0] ist_q, ist_d, imask_q;
	logic sre_q, irq_q;
	out_state_e st_q, st_d;
	logic txv_q, txv_d, eoi_q, eoi_d;
	logic [7:0] txb_q, txb_d;
	logic start_q, impl_q, fmtr_q;
	logic cv_q, ceol_q, clr_q, trig_q, save_q;
	logic [7:0] cb_q;
	logic rem_q, rem_d, lock_q, lock_d, led_q;
	logic [31:0] blink_q;
	logic key_s1_q, key_s2_q, key_s3_q;

	wire clr_any = bus_evt.dcl | bus_evt.sdc | bus_evt.ifc;
	wire fast = ~mode_q;
	wire accept = rx_valid & rx_ready;
	wire term = accept & rx_eoi & (rx_byte == `LF_BYTE);
	wire wr_ctrl = reg_wr & (reg_addr == `OFS_CTRL);
	wire wr_ist = reg_wr & (reg_addr == `OFS_ISTAT);
	wire wr_imask = reg_wr & (reg_addr == `OFS_IMASK);
	wire wr_sre = reg_wr & (reg_addr == `OFS_SRE);
	wire mode_chg = wr_ctrl & (reg_wdata[`CTRL_MEP] != mode_q);
	wire early_rd = talk_addr & tx_req & open_q;
	wire go_out = (st_q == OUT_IDLE) & ~stuck_q & ~clr_any;
	// Fast mode defers formatting to the first data request; full mode
	// formats as soon as the query finishes.
	wire fast_go = go_out & fast & talk_addr & tx_req & ~open_q;
	wire full_go = go_out & ~fast & pend_q & query_done;
	wire sent_last = (st_q == OUT_SEND) & tx_take & txv_q & eoi_q;
	wire key_press = key_s2_q & ~key_s3_q;
	wire [`EV_N-1:0] evt = {bus_evt.get, clr_any, exec_error, query_done, term};
	wire [`EV_N-1:0] ist_clr = wr_ist ? reg_wdata[`EV_N-1:0] : '0;

	// Mode: loaded from storage once after reset, changed by software only.
	// A change drops remote and pulses nv_save so the new mode is stored.
	assign mode_d = !loaded_q ? nv_mode : (wr_ctrl ? reg_wdata[`CTRL_MEP] : mode_q);
	// Hold-off and the input wedge after an early read.
	assign open_d = clr_any ? 1'b0 : (term ? 1'b0 : (accept ? 1'b1 : open_q));
	assign hold_d = clr_any | exec_done | exec_error ? 1'b0 : (term & fast) | hold_q;
	assign stuck_d = clr_any ? 1'b0 : (early_rd | stuck_q);
	// Pending query and message available.
	assign pend_d = clr_any | sent_last ? 1'b0 : (query_seen | pend_q);
	always_comb begin
		mav_d = mav_q;
		if (fast && query_done) begin
			mav_d = 1'b1;
		end else if (!fast && st_q == OUT_SEND) begin
			mav_d = 1'b1;
		end
		if (clr_any || sent_last) begin
			mav_d = 1'b0;
		end
	end
	// Bytes go to the parser untouched, so every command form still parses.
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_q <= `MEP_RESET;
			loaded_q <= 1'b0;
			save_q <= 1'b0;
			hold_q <= 1'b0;
			stuck_q <= 1'b0;
			open_q <= 1'b0;
			pend_q <= 1'b0;
			mav_q <= 1'b0;
			cv_q <= 1'b0;
			cb_q <= 8'h00;
			ceol_q <= 1'b0;
			clr_q <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			loaded_q <= 1'b1;
			save_q <= mode_chg;
			hold_q <= hold_d;
			stuck_q <= stuck_d;
			open_q <= open_d;
			pend_q <= pend_d;
			mav_q <= mav_d;
			cv_q <= accept;
			cb_q <= rx_byte;
			ceol_q <= term;
			clr_q <= clr_any;
			trig_q <= bus_evt.get;
		end
	end

	// Output task. The state survives loss of talk addressing, so a long reply
	// can be fetched in pieces; it ends only on the EOI byte or a clear.
	always_comb begin
		st_d = st_q;
		txv_d = txv_q;
		txb_d = txb_q;
		eoi_d = eoi_q;
		unique case (st_q)
			OUT_IDLE: begin
				if (fast_go || full_go) begin
					st_d = OUT_FMT;
				end
			end
			OUT_FMT: begin
				if (fmt_in.valid) begin
					st_d = OUT_SEND;
					txv_d = 1'b1;
					txb_d = fmt_in.data;
					eoi_d = fmt_in.last;
				end
			end
			OUT_SEND: begin
				if (tx_take && talk_addr) begin
					txv_d = 1'b0;
					st_d = eoi_q ? OUT_IDLE : OUT_FMT;
				end
			end
			default: begin
				st_d = OUT_IDLE;
			end
		endcase
		if (clr_any) begin
			st_d = OUT_IDLE;
			txv_d = 1'b0;
			eoi_d = 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= OUT_IDLE;
			txv_q <= 1'b0;
			txb_q <= 8'h00;
			eoi_q <= 1'b0;
			start_q <= 1'b0;
			impl_q <= 1'b0;
			fmtr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			txv_q <= txv_d;
			txb_q <= txb_d;
			eoi_q <= eoi_d;
			start_q <= fast_go | full_go;
			impl_q <= fast_go & ~pend_q;
			fmtr_q <= (st_d == OUT_FMT);
		end
	end

	// Remote, lockout and the local key. In fast mode go-to-local only drops
	// lockout; a busy instrument may not honour it at once.
	always_comb begin
		rem_d = rem_q;
		lock_d = lock_q;
		if (ren && (accept || talk_addr)) begin
			rem_d = 1'b1;
		end
		if (ren && bus_evt.llo) begin
			lock_d = 1'b1;
		end
		if (bus_evt.gtl) begin
			lock_d = 1'b0;
			if (!fast) begin
				rem_d = 1'b0;
			end
		end
		if (key_press && !lock_q) begin
			rem_d = 1'b0;
		end
		if (!ren || mode_chg) begin
			rem_d = 1'b0;
		end
		if (!ren) begin
			lock_d = 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			key_s1_q <= 1'b0;
			key_s2_q <= 1'b0;
			key_s3_q <= 1'b0;
			rem_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			key_s1_q <= local_key;
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
			rem_q <= rem_d;
			lock_q <= lock_d;
		end
	end

	// Blinking remote indicator, same in both modes.
	wire blink_wrap = (blink_q == 32'(BLINK_CYC - 1));
	always_ff @(posedge mclk) begin
		if (rst || !rem_q) begin
			blink_q <= 32'h0;
			led_q <= 1'b0;
		end else begin
			blink_q <= blink_wrap ? 32'h0 : blink_q + 32'h1;
			led_q <= blink_wrap ? ~led_q : (led_q | (blink_q == 32'h0));
		end
	end

	// Registers and interrupt; a new event beats a clear in the same cycle.
	assign ist_d = (ist_q & ~ist_clr) | evt;
	wire [31:0] stat_word = {24'h0, lock_q, rem_q, mav_q, pend_q, txv_q, stuck_q, hold_q, mode_q};
	assign rdata_d = !reg_rd ? 32'h0 :
		(reg_addr == `OFS_CTRL) ? {31'h0, mode_q} :
		(reg_addr == `OFS_STAT) ? stat_word :
		(reg_addr == `OFS_ISTAT) ? {27'h0, ist_q} :
		(reg_addr == `OFS_IMASK) ? {27'h0, imask_q} :
		(reg_addr == `OFS_SRE) ? {31'h0, sre_q} : 32'h0;
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 32'h0;
			ist_q <= '0;
			imask_q <= '0;
			sre_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ist_q <= ist_d;
			imask_q <= wr_imask ? reg_wdata[`EV_N-1:0] : imask_q;
			sre_q <= wr_sre ? reg_wdata[0] : sre_q;
			irq_q <= |(ist_d & (wr_imask ? reg_wdata[`EV_N-1:0] : imask_q));
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign rx_ready = ~hold_q & ~stuck_q;
	assign cmd_valid = cv_q;
	assign cmd_byte = cb_q;
	assign cmd_eol = ceol_q;
	assign dev_clear = clr_q;
	assign tx_valid = txv_q;
	assign tx_byte = txb_q;
	assign tx_eoi = eoi_q;
	assign fmt_start = start_q;
	assign fmt_implied = impl_q;
	assign fmt_ready = fmtr_q;
	assign stb = {1'b0, mav_q & sre_q, 1'b0, mav_q, 4'h0};
	assign srq = mav_q & sre_q;
	assign trig = trig_q;
	assign mep_on = mode_q;
	assign nv_save = save_q;
	assign remote_led = led_q;
	assign lockout = lock_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_hold_term: assert property (term && fast && !clr_any && !exec_done && !exec_error
		|=> !rx_ready until (exec_done || exec_error || clr_any))
		else $error("hold-off missing after terminator");
	chk_hold_free: assert property (hold_q && !stuck_q && exec_error && !early_rd
		|=> rx_ready)
		else $error("hold-off not released on error");
	chk_clear_all: assert property (clr_any |=> !pend_q && !mav_q && st_q == OUT_IDLE
		&& !stuck_q && dev_clear)
		else $error("clear left query or output state");
	chk_early_read: assert property (early_rd && !clr_any |=> !rx_ready[*2])
		else $error("early read did not wedge input");
	chk_implied_read: assert property (fast_go && !pend_q |=> fmt_start && fmt_implied)
		else $error("trigger-on-talk missing");
	chk_mav_fast: assert property (fast && query_done && !clr_any && !sent_last
		|=> stb[`STB_MAV])
		else $error("message available late");
	chk_defer_fmt: assert property ($rose(fmt_start) && fast |-> $past(tx_req))
		else $error("formatting started without request");
	chk_get_trig: assert property (bus_evt.get |=> trig)
		else $error("trigger pulse missing");
	chk_gtl_lock: assert property (bus_evt.gtl && ren |=> !lockout)
		else $error("go-to-local kept lockout");
	chk_mep_read: assert property (reg_rd && reg_addr == `OFS_CTRL
		|=> reg_rdata[0] == $past(mode_q))
		else $error("mode readback wrong");
	chk_reply_hold: assert property (tx_valid && !tx_take && !clr_any
		|=> tx_valid && $stable(tx_byte))
		else $error("reply byte lost between talks");

	cov_implied: cover property (fmt_start && fmt_implied);
	cov_split_reply: cover property (tx_valid && !talk_addr ##1 talk_addr && tx_take);
	cov_hold_cycle: cover property (term ##[1:20] exec_done);
	cov_clear_stuck: cover property (stuck_q ##1 clr_any);
endmodule
`default_nettype wire
